/* File: logic/scoc_ctrl.sv */
// Top of the SPI output controller: instruction decode, select and serial state
// registers, power stage drive. Assumes slave select stays high for at least
// four system clock periods between frames.
`timescale 1ns/1ns
module scoc_ctrl import scoc_pkg::*; (
    input  wire logic                     mclk,                 // System clock
    input  wire logic                     rst_n,                // Reset, low active; synchronous here, asynchronous in u_link
    input  wire logic                     sck,                  // Serial clock
    input  wire logic                     ss_n,                 // Slave select pin
    input  wire logic                     si,                   // Serial data in
    output logic                          so,                   // Serial data out
    output logic                          so_oe_n,              // Low while driving
    input  wire logic                     supervisor_shutoff_n, // Shutoff pin
    input  wire logic [PIN_STAGES-1:0]    parallel_input_pin,   // Stage pins
    input  wire logic [PIN_STAGES-1:0]    fast_bus_stage_bit,   // From fast-bus block
    input  wire logic                     bus_select,           // 1 pins, 0 fast bus
    input  wire logic [EXT_REGS-1:0][7:0] ext_regs,             // Registers read only here
    output logic      [STAGES-1:0]        power_stage_output,   // 1 = stage on
    output logic                          clear_diagnostics,    // One-cycle pulse
    output logic                          status_write,         // One-cycle pulse
    output logic                          config_write,         // One-cycle pulse
    output logic      [7:0]               write_data,           // Data of last write
    output logic                          transfer_error_flag   // Error of last addressed frame
);
    scoc_link_if lnk ();

    logic        ss_m, ss_s, ss_q;
    logic [2:0]  tog_m, tog_s, tog_seen;
    logic        sup_m, sup_s;
    logic [15:0] pin_m, pin_s;
    logic [7:0]  source_select_low;
    logic [7:0]  source_select_high;
    logic [17:0] serial_state;
    logic [17:0] next_stage_on;

    ////////////////////////////////////////////////////////////////////////////////
    // Serial clock side
    scoc_spi_link u_link (
        .sck     (sck),
        .ss_n    (ss_n),
        .si      (si),
        .rst_n   (rst_n),
        .so      (so),
        .so_oe_n (so_oe_n),
        .lnk     (lnk.link)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // Synchronisers for pins and link toggles
    always_ff @(posedge mclk)
    begin
        ss_m  <= ss_n;
        ss_s  <= ss_m;
        tog_m <= lnk.tog;
        tog_s <= tog_m;
        sup_m <= supervisor_shutoff_n;
        sup_s <= sup_m;
        pin_m <= parallel_input_pin;
        pin_s <= pin_m;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame decode at the rising edge of slave select
    wire logic       frame_end = ss_s & ~ss_q;
    wire logic [2:0] tog_new   = tog_s ^ tog_seen;
    wire logic       selected  = tog_new[TOG_ADDR];                      // see R17
    wire logic       cnt_ok    = tog_new[TOG_FULL] & ~tog_new[TOG_OVER]; // see R19
    wire logic [4:0] code      = lnk.frame_word[W_CODE_LSB +: 5];
    wire logic [7:0] data      = lnk.frame_word[7:0];
    wire scoc_kind_e kind      = scoc_code_kind(code);
    wire logic       par_ok    = (^code) == lnk.frame_word[W_PAR];       // see R5
    wire logic       good      = selected & cnt_ok & par_ok & (kind != K_UNUSED);
    wire logic       apply     = frame_end & good;
    wire logic       flag_upd  = frame_end & selected;

    // Edge detector idles high, so reset release gives no false frame end
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            ss_q     <= 1'b1;
            tog_seen <= '0;
        end
        else
        begin
            ss_q <= ss_s;
            if (frame_end)
                tog_seen <= tog_s;
        end
    end

    // Read view indexed by the low four bits of a read code
    assign lnk.reg_view = {ext_regs[10:3], ext_regs[2],
                           {SER_C_FILL, serial_state[17:16]},
                           serial_state[15:8], serial_state[7:0],
                           source_select_high, source_select_low,     // see R16
                           ext_regs[1:0]};                           // see R1
    assign lnk.error_flag = transfer_error_flag;

    ////////////////////////////////////////////////////////////////////////////////
    // Registers written by instructions
    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            source_select_low  <= SRC_LOW_RST;                      // see R14
            source_select_high <= SRC_HIGH_RST;                     // see R15
            serial_state       <= SER_RST;
        end
        else if (apply)
        begin
            case (code)
                CODE_WR_SEL_LOW:  source_select_low   <= data;      // see R16
                CODE_WR_SEL_HIGH: source_select_high  <= data;
                CODE_WR_SER_A:    serial_state[7:0]   <= data;
                CODE_WR_SER_B:    serial_state[15:8]  <= data;
                CODE_WR_SER_C:    serial_state[17:16] <= data[1:0];
                default:          serial_state        <= serial_state;
            endcase
        end
    end

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
        begin
            clear_diagnostics   <= 1'b0;
            status_write        <= 1'b0;
            config_write        <= 1'b0;
            write_data          <= '0;
            transfer_error_flag <= 1'b0;
        end
        else
        begin
            clear_diagnostics <= apply & (code == CODE_CLEAR_DIAG);  // see R4
            status_write      <= apply & (code == CODE_WR_STATUS);
            config_write      <= apply & (code == CODE_WR_CONFIG);
            if (apply && kind == K_WRITE)
                write_data <= data;
            // Flag was sent in this frame; a new error sets it again
            if (flag_upd)
                transfer_error_flag <= ~good;                        // see R18
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Power stage drive
    scoc_stage_mux u_mux (
        .source_bits (({source_select_high, source_select_low})),
        .pins        (pin_s),
        .fast_bits   (fast_bus_stage_bit),                           // see R20
        .serial_bits (serial_state),
        .bus_select  (bus_select),
        .enable      (sup_s),
        .stage_on    (next_stage_on)
    );

    always_ff @(posedge mclk)
    begin
        if (!rst_n)
            power_stage_output <= '0;                                // see R7
        else
            power_stage_output <= next_stage_on;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_shutoff;
        !sup_s |=> power_stage_output == '0;
    endproperty
    a_shutoff: assert property (p_shutoff) else $error("stage on during shutoff"); // see R7

    property p_serial;
        sup_s && !source_select_low[0] |=> power_stage_output[0] == !$past(serial_state[0]);
    endproperty
    a_serial: assert property (p_serial) else $error("serial control wrong"); // see R8

    property p_parallel;
        sup_s && source_select_low[0] && bus_select
            |=> power_stage_output[0] == !$past(pin_s[0]);
    endproperty
    a_parallel: assert property (p_parallel) else $error("parallel control wrong"); // see R9

    property p_fast;
        sup_s && source_select_low[1] && !bus_select
            |=> power_stage_output[1] == !$past(fast_bus_stage_bit[1]);
    endproperty
    a_fast: assert property (p_fast) else $error("fast bus control wrong"); // see R10

    property p_eight_par;
        sup_s && source_select_low[7] && bus_select
            |=> power_stage_output[7] == $past(pin_s[7]);
    endproperty
    a_eight_par: assert property (p_eight_par) else $error("stage eight inverted"); // see R11

    property p_eight_fast;
        sup_s && source_select_low[7] && !bus_select
            |=> power_stage_output[7] == $past(pin_s[7]);
    endproperty
    a_eight_fast: assert property (p_eight_fast) else $error("stage eight on fast bus"); // see R12

    property p_tail;
        sup_s |=> power_stage_output[17:16] == ~$past(serial_state[17:16]);
    endproperty
    a_tail: assert property (p_tail) else $error("stages 17 18 wrong"); // see R13

    property p_src_low_rst;
        $rose(rst_n) |-> source_select_low == SRC_LOW_RST;
    endproperty
    a_src_low_rst: assert property (p_src_low_rst) else $error("low select reset"); // see R14

    property p_src_high_rst;
        $rose(rst_n) |-> source_select_high == SRC_HIGH_RST;
    endproperty
    a_src_high_rst: assert property (p_src_high_rst) else $error("high select reset"); // see R15

    property p_write_low;
        apply && code == CODE_WR_SEL_LOW |=> source_select_low == $past(data);
    endproperty
    a_write_low: assert property (p_write_low) else $error("select write lost"); // see R16

    property p_clear;
        apply && code == CODE_CLEAR_DIAG |=> clear_diagnostics ##1 !clear_diagnostics;
    endproperty
    a_clear: assert property (p_clear) else $error("clear pulse wrong"); // see R4

    property p_unused;
        frame_end && kind == K_UNUSED
            |=> $stable(serial_state) && !status_write && !config_write;
    endproperty
    a_unused: assert property (p_unused) else $error("unused code acted"); // see R6

    property p_bad_count;
        frame_end && !cnt_ok |=> $stable(source_select_low) && $stable(source_select_high)
            && !clear_diagnostics;
    endproperty
    a_bad_count: assert property (p_bad_count) else $error("short frame acted"); // see R19

    property p_bad_flag;
        flag_upd && !good |=> transfer_error_flag [*2];
    endproperty
    a_bad_flag: assert property (p_bad_flag) else $error("error flag not set"); // see R18

    c_write:   cover property (apply && kind == K_WRITE);
    c_clear:   cover property (apply && kind == K_CLEAR);
    c_invalid: cover property (flag_upd && !good);
    c_par:     cover property (sup_s && source_select_low[0] && bus_select);
endmodule : scoc_ctrl

/* File: logic/scoc_link_if.sv */
// Signals passing between the serial clock side and the system clock side.
// Words are only read while the serial clock stands still after a frame.
`timescale 1ns/1ns
interface scoc_link_if;
    logic [15:0]      frame_word;
    logic [2:0]       tog;
    logic [15:0][7:0] reg_view;
    logic             error_flag;
    modport link (output frame_word, tog, input reg_view, error_flag);
    modport ctrl (input frame_word, tog, output reg_view, error_flag);
endinterface : scoc_link_if

/* File: logic/scoc_pkg.sv */
// Constants, instruction codes and decode helper of the SPI output controller.
// Assumes a 16-bit SPI frame, MSB first, data sampled on rising serial clock.
// Function
// R1: Read codes for identifiers, select, serial state, status.
// R2: Read codes for diagnostics, configuration and inputs.
// R3: Write codes for status, select, serial state, configuration.
// R4: Code 11000 clears all five diagnostic registers.
// R5: Parity bit equals XOR of code bits.
// R6: Unlisted codes have no function.
// R7: Shutoff or reset low forces every stage off.
// R8: Select bit 0: stage follows inverted serial bit.
// R9: Select 1, bus select 1: follow inverted pin.
// R10: Select 1, bus select 0: follow inverted fast bit.
// R11: Stage eight parallel control is non-inverting.
// R12: Stage eight never driven by fast bus.
// R13: Stages 17, 18 follow serial bits only.
// R14: Low select register drives stages 1-8, resets 80h.
// R15: High select register drives stages 9-16, resets 00h.
// R16: Both select registers are readable and writable.
// R17: Chip address 00 in bits 7 and 6.
// R18: Invalid instruction: no write, FFh back, error flag.
// R19: Write or clear needs exactly 16 clock edges.
// R20: Fast-bus bits come from separate receiver, not stage eight.
package scoc_pkg;
    localparam int STAGES      = 18;
    localparam int PIN_STAGES  = 16;
    localparam int EXT_REGS    = 11;
    localparam int STAGE_EIGHT = 7;

    localparam logic [4:0] CODE_RD_IDENT_A = 5'h00, CODE_RD_IDENT_B = 5'h01,
        CODE_RD_SEL_LOW = 5'h02, CODE_RD_SEL_HIGH = 5'h03, CODE_RD_SER_A = 5'h04,
        CODE_RD_SER_B = 5'h05, CODE_RD_SER_C = 5'h06, CODE_RD_STATUS = 5'h07,
        CODE_RD_DIAG_A = 5'h08, CODE_RD_DIAG_E = 5'h0c, CODE_RD_CONFIG = 5'h0d,
        CODE_RD_INPUT_A = 5'h0e, CODE_RD_INPUT_B = 5'h0f;
    localparam logic [4:0] CODE_WR_STATUS = 5'h11, CODE_WR_SEL_LOW = 5'h12,
        CODE_WR_SEL_HIGH = 5'h13, CODE_WR_SER_A = 5'h14, CODE_WR_SER_B = 5'h15,
        CODE_WR_SER_C = 5'h16, CODE_WR_CONFIG = 5'h17, CODE_CLEAR_DIAG = 5'h18;

    localparam logic [1:0]  CHIP_ADDR    = 2'h0;
    localparam logic [4:0]  VERIFY_PAT   = 5'h15;
    localparam logic [7:0]  RESP_INVALID = 8'hff;
    localparam logic [7:0]  RESP_WRITE   = 8'h00;
    localparam logic [7:0]  SRC_LOW_RST  = 8'h80;
    localparam logic [7:0]  SRC_HIGH_RST = 8'h00;
    localparam logic [17:0] SER_RST      = 18'h3ffff;
    localparam logic [5:0]  SER_C_FILL   = 6'h3f;

    // Frame positions, counted in rising serial clock edges already seen
    localparam logic [4:0] POS_ADDR   = 5'h01;
    localparam logic [4:0] POS_VERIFY = 5'h02;
    localparam logic [4:0] POS_FLAG   = 5'h07;
    localparam logic [4:0] POS_DATA   = 5'h08;
    localparam logic [4:0] POS_LAST   = 5'h0f;
    localparam logic [4:0] POS_OVER   = 5'h10;
    localparam logic [4:0] CNT_SAT    = 5'h11;

    // Frame word fields and toggle lanes
    localparam int W_ADDR_LSB = 14;
    localparam int W_CODE_LSB = 9;
    localparam int W_PAR      = 8;
    localparam int TOG_ADDR   = 0;
    localparam int TOG_FULL   = 1;
    localparam int TOG_OVER   = 2;

    typedef enum logic [3:0] {
        K_READ   = 4'b0001,
        K_WRITE  = 4'b0010,
        K_CLEAR  = 4'b0100,
        K_UNUSED = 4'b1000
    } scoc_kind_e;

    function automatic scoc_kind_e scoc_code_kind(input logic [4:0] code);
        scoc_kind_e k;
        k = K_UNUSED;                                            // see R6
        if (code <= CODE_RD_INPUT_B)
            k = K_READ;                                          // see R1
        else if (code >= CODE_WR_STATUS && code <= CODE_WR_CONFIG)
            k = K_WRITE;                                         // see R3
        else if (code == CODE_CLEAR_DIAG)
            k = K_CLEAR;                                         // see R4
        return k;
    endfunction : scoc_code_kind
endpackage : scoc_pkg

/* File: logic/scoc_spi_link.sv */
// Serial clock side: shifts the frame in, drives the verification bits, error flag and data byte.
// Assumes slave select high between frames and the serial clock idle then.
`timescale 1ns/1ns
module scoc_spi_link import scoc_pkg::*; (
    input  wire logic  sck,     // Serial clock from master
    input  wire logic  ss_n,    // Slave select, frame signal
    input  wire logic  si,      // Serial data in
    input  wire logic  rst_n,   // Device reset, low active
    output logic       so,      // Serial data out level
    output logic       so_oe_n, // Low while driving
    scoc_link_if.link  lnk      // To system clock side
);
    logic [4:0]  cnt;
    logic        sel;
    logic [14:0] shift;
    logic [7:0]  resp;

    wire logic       addr_hit = {shift[0], si} == CHIP_ADDR;            // see R17
    wire logic [4:0] code     = shift[5:1];
    wire scoc_kind_e kind     = scoc_code_kind(code);
    wire logic [2:0] vidx     = 3'(POS_FLAG - 5'h01 - cnt);
    wire logic [7:0] resp_now = (kind == K_READ) ? lnk.reg_view[code[3:0]] :
                                (kind == K_UNUSED) ? RESP_INVALID : RESP_WRITE; // see R18

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(posedge sck or posedge ss_n)
    begin
        if (ss_n)
        begin
            cnt <= '0;
            sel <= 1'b0;
        end
        else
        begin
            if (cnt != CNT_SAT)
                cnt <= cnt + 5'h01;
            if (cnt == POS_ADDR)
                sel <= addr_hit;
        end
    end

    always_ff @(posedge sck)
        shift <= {shift[13:0], si};

    // Toggles mark events; the word is stable once the clock stops
    always_ff @(posedge sck or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lnk.tog        <= '0;
            lnk.frame_word <= '0;
        end
        else
        begin
            if (cnt == POS_ADDR && addr_hit)
                lnk.tog[TOG_ADDR] <= ~lnk.tog[TOG_ADDR];
            if (cnt == POS_LAST)
            begin
                lnk.tog[TOG_FULL] <= ~lnk.tog[TOG_FULL];
                lnk.frame_word    <= {shift, si};
            end
            if (cnt == POS_OVER)
                lnk.tog[TOG_OVER] <= ~lnk.tog[TOG_OVER];               // see R19
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    always_ff @(negedge sck or posedge ss_n or negedge rst_n)
    begin
        if (ss_n || !rst_n)
        begin
            so      <= 1'b0;
            so_oe_n <= 1'b1;
            resp    <= '0;
        end
        else if (sel && cnt >= POS_VERIFY)
        begin
            so_oe_n <= 1'b0;
            if (cnt < POS_FLAG)
                so <= VERIFY_PAT[vidx];
            else if (cnt == POS_FLAG)
                so <= lnk.error_flag;                                    // see R18
            else if (cnt == POS_DATA)
            begin
                so   <= resp_now[7];
                resp <= {resp_now[6:0], 1'b0};
            end
            else if (cnt <= POS_LAST)
            begin
                so   <= resp[7];
                resp <= {resp[6:0], 1'b0};
            end
            else
                so <= 1'b0;
        end
    end
endmodule : scoc_spi_link

/* File: logic/scoc_stage_mux.sv */
// Per-stage source selection; gives the next on state of every power stage.
// Assumes all inputs already in the system clock domain.
`timescale 1ns/1ns
module scoc_stage_mux import scoc_pkg::*; #(
    parameter int N    = STAGES,
    parameter int PINS = PIN_STAGES
) (
    input  wire logic [PINS-1:0] source_bits, // One select bit per pin stage
    input  wire logic [PINS-1:0] pins,        // Synchronised parallel pins
    input  wire logic [PINS-1:0] fast_bits,   // Fast-bus stage bits
    input  wire logic [N-1:0]    serial_bits, // Serial state bits
    input  wire logic            bus_select,  // 1 pins, 0 fast bus
    input  wire logic            enable,      // Synchronised shutoff pin high
    output logic      [N-1:0]    stage_on     // Next on state
);
    for (genvar i = 0; i < N; i++)
    begin : g_stage
        if (i >= PINS)
        begin : g_serial_only
            assign stage_on[i] = enable & ~serial_bits[i];                 // see R13
        end
        else if (i == STAGE_EIGHT)
        begin : g_eight
            // Non-inverting, and the fast bus has no path here
            assign stage_on[i] = enable & (source_bits[i] ? pins[i]         // see R11
                                                          : ~serial_bits[i]); // see R12
        end
        else
        begin : g_muxed
            wire logic ext_on = bus_select ? ~pins[i] : ~fast_bits[i];     // see R9
            assign stage_on[i] = enable & (source_bits[i] ? ext_on          // see R10
                                                          : ~serial_bits[i]); // see R8
        end
    end
endmodule : scoc_stage_mux

/* File: testbench/scoc_master.sv */
// SPI master model: frames of any bit count, serial clock only inside frames.
// Assumes the device samples on rising and shifts on falling serial clock.
`timescale 1ns/1ns
module scoc_master (
    output logic      sck,    // Serial clock, low between frames
    output logic      ss_n,   // Slave select
    output logic      si,     // Data to device
    input  wire logic so,     // Data from device
    input  wire logic so_oe_n // Low while device drives
);
    initial
    begin
        sck  = 1'b0;
        ss_n = 1'b1;
        si   = 1'b0;
    end
    ////////////////////////////////////////
    function automatic logic [15:0] word(input logic [1:0] a, input logic [4:0] c,
                                         input logic [7:0] d);
        return {a, c, ^c, d};
    endfunction : word
    // Counts other than 16 are deliberate refusal cases
    task automatic xfer(input logic [15:0] w, input int n, output logic [15:0] rx);
        rx   = 16'hzzzz;
        ss_n = 1'b0;
        #25;
        for (int i = 0; i < n; i++)
        begin
            si = (i < 16) ? w[15-i] : ~si;
            #6 sck = 1'b1;
            if (i < 16)
                rx[15-i] = so_oe_n ? 1'bz : so;
            #6 sck = 1'b0;
        end
        #25 ss_n = 1'b1;
        si = ~si; // Released line shows no stale bit
        #700;
    endtask : xfer
endmodule : scoc_master

/* File: testbench/tb_scoc_ctrl.sv */
// Testbench of the SPI output controller: register frames, stage control, refusals.
// Assumes the master model owns the serial pins; other inputs change on falling mclk.
`timescale 1ns/1ns
module tb_scoc_ctrl import scoc_pkg::*;;
    logic              mclk, rst_n, sck, ss_n, si, so, so_oe_n, sh_n, bus_select, ef;
    logic              clr, stw, cfw, flag;
    logic [15:0]       pins, fast;
    logic [10:0][7:0]  ext;
    logic [17:0]       outs, ser;
    logic [7:0]        wdata, sel_lo, sel_hi;
    int                fail_count, comparisons, n_clr, n_st, n_cf, e_clr, e_st, e_cf;
    scoc_ctrl u_scoc_ctrl (.mclk, .rst_n, .sck, .ss_n, .si, .so, .so_oe_n,
        .supervisor_shutoff_n(sh_n), .parallel_input_pin(pins), .fast_bus_stage_bit(fast),
        .bus_select, .ext_regs(ext), .power_stage_output(outs), .clear_diagnostics(clr),
        .status_write(stw), .config_write(cfw), .write_data(wdata),
        .transfer_error_flag(flag));
    scoc_master u_scoc_master (.sck, .ss_n, .si, .so, .so_oe_n);
    always #50 mclk = ~mclk;
    always @(posedge mclk)
    begin
        if (clr === 1'b1) n_clr++;
        if (stw === 1'b1) n_st++;
        if (cfw === 1'b1) n_cf++;
    end
    ////////////////////////////////////////
    task automatic check(input string s, input logic [17:0] e, input logic [17:0] g);
        comparisons++;
        if (g !== e)
        begin
            fail_count++;
            $display("unexpected %s: expected %h, seen %h", s, e, g);
        end
    endtask : check
    function automatic logic [7:0] rd(input logic [4:0] c);
        case (c)
            5'h00, 5'h01: return ext[c];
            5'h02: return sel_lo;
            5'h03: return sel_hi;
            5'h04: return ser[7:0];
            5'h05: return ser[15:8];
            5'h06: return {6'h3f, ser[17:16]};
            5'h07: return ext[2];
            default: return (c < 5'h10) ? ext[c - 5'h05] : 8'hff;
        endcase
    endfunction : rd
    task automatic spi(input logic [4:0] c, input logic [7:0] d, input logic [1:0] a = 2'h0,
                       input int n = 16, input logic bad = 1'b0);
        logic [15:0] rx;
        logic        wr;
        logic        ok;
        wr = c >= 5'h11 && c <= 5'h18;
        ok = a == 2'h0 && n == 16 && !bad && (wr || c < 5'h10);
        u_scoc_master.xfer(u_scoc_master.word(a, c, d) ^ {7'h0, bad, 8'h0}, n, rx);
        @(negedge mclk);
        if (n == 16)
            check("response", a != 2'h0 ? 16'hzzzz
                : {2'hz, VERIFY_PAT, ef, wr ? 8'h00 : rd(c)}, rx);
        if (a == 2'h0)
            ef = !ok;
        if (ok && wr)
        begin
            case (c)
                5'h12: sel_lo = d;
                5'h13: sel_hi = d;
                5'h14: ser[7:0] = d;
                5'h15: ser[15:8] = d;
                5'h16: ser[17:16] = d[1:0];
                5'h11: e_st++;
                5'h17: e_cf++;
                default: e_clr++;
            endcase
            if (c != 5'h18)
                check("write data", d, wdata);
        end
        check("error flag", ef, flag);
        check("pulses", {6'(e_clr), 6'(e_st), 6'(e_cf)}, {6'(n_clr), 6'(n_st), 6'(n_cf)});
    endtask : spi
    task automatic stages();
        logic [17:0] e;
        logic        s;
        repeat (5) @(negedge mclk);
        for (int i = 0; i < 18; i++)
        begin
            s = i < 8 ? sel_lo[i] : (i < 16 ? sel_hi[i-8] : 1'b0);
            e[i] = !s ? !ser[i] : i == 7 ? pins[7] : bus_select ? !pins[i] : !fast[i];
        end
        check("stage outputs", e & {18{sh_n}}, outs);
    endtask : stages
    task automatic test_done();
        $display("comparisons %0d, mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : test_done
    ////////////////////////////////////////
    initial
    begin
        {mclk, rst_n, bus_select, sh_n, ef} = 5'h06;
        {pins, fast} = {16'h5a3c, 16'hc35a};
        for (int i = 0; i < 11; i++) ext[i] = 8'ha0 + 8'(i);
        {sel_lo, sel_hi, ser} = {SRC_LOW_RST, SRC_HIGH_RST, SER_RST};
        repeat (10) @(negedge mclk);
        check("reset outputs", 18'h0, outs);
        rst_n = 1'b1;
        repeat (5) @(negedge mclk);
        for (int c = 0; c < 16; c++) spi(5'(c), 8'h00);
        spi(5'h11, 8'h3c);
        spi(5'h17, 8'hc3);
        spi(5'h13, 8'ha5);
        spi(5'h03, 8'h00);
        $display("test registers done");
        stages();
        pins[7] = 1'b1;
        stages();
        spi(5'h14, 8'h00);
        spi(5'h16, 8'h02);
        stages();
        spi(5'h12, 8'h7f);
        stages();
        bus_select = 1'b0;
        stages();
        spi(5'h12, 8'hff);
        stages();
        bus_select = 1'b1;
        $display("test stages done");
        spi(5'h19, 8'h00);
        spi(5'h10, 8'h00);
        spi(5'h12, 8'h00, 2'h0, 16, 1'b1);
        spi(5'h12, 8'h00, 2'h1);
        spi(5'h12, 8'h00, 2'h0, 15);
        spi(5'h02, 8'h00);
        spi(5'h18, 8'h00);
        $display("test refusals done");
        sh_n = 1'b0;
        stages();
        sh_n = 1'b1;
        stages();
        rst_n = 1'b0;
        repeat (3) @(negedge mclk);
        check("reset outputs", 18'h0, outs);
        $display("test gating done");
        test_done();
    end
    initial
    begin
        #400000;
        fail_count++;
        $display("unexpected watchdog: expected end, seen timeout");
        test_done();
    end
endmodule : tb_scoc_ctrl
